// *** core/dual_adc_pkg.sv ***
// Shared constants for the dual converter link
package dual_adc_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLOCK_PERIOD_NS     = 100;
  localparam int TRIGGER_HIGH_NS     = 15;
  localparam int TRIGGER_HIGH_CYCLES =
    (TRIGGER_HIGH_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int ADC_CLOCK_DIVIDE    = 8;
  localparam int ADC_CLOCK_HALF      = ADC_CLOCK_DIVIDE / 2;
  localparam int DIVIDER_BITS        = $clog2(ADC_CLOCK_DIVIDE);

  // ----------------------------------------
  // Frame layout
  // ----------------------------------------
  localparam int DATA_BITS         = 12;
  localparam int FRAME_BITS        = 16;
  localparam int BUSY_DROP_INDEX   = 12;
  localparam int FIRST_CYCLE_COUNT = 1;
  localparam int SYNC_PINS_DEVICE  = 6;
  localparam int SYNC_PINS_HOST    = 3;

  // ----------------------------------------
  // Controller registers
  // ----------------------------------------
  localparam int         ADDR_BITS         = 8;
  localparam logic [7:0] CONTROL_OFFSET    = 8'h00;
  localparam logic [7:0] STATUS_OFFSET     = 8'h04;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h08;
  localparam logic [7:0] IRQ_CLEAR_OFFSET  = 8'h0C;
  localparam logic [7:0] IRQ_ENABLE_OFFSET = 8'h10;
  localparam logic [7:0] RESULT_A_OFFSET   = 8'h14;
  localparam logic [7:0] RESULT_B_OFFSET   = 8'h18;

  localparam int CONTROL_CHANNEL_COUNT_BIT = 0;
  localparam int CONTROL_OUTPUT_PORT_BIT   = 1;
  localparam int CONTROL_PAIR_BIT          = 2;
  localparam int CONTROL_START_BIT         = 3;
  localparam int CONTROL_BITS              = 3;
  localparam int STATUS_ACTIVE_BIT         = 0;
  localparam int STATUS_BUSY_BIT           = 1;
  localparam int IRQ_DONE_BIT              = 0;
  localparam int IRQ_REFUSED_BIT           = 1;
  localparam int IRQ_BITS                  = 2;

  localparam logic [2:0] CONTROL_RESET    = 3'h0;
  localparam logic [1:0] IRQ_ENABLE_RESET = 2'h0;
  localparam logic [1:0] RESP_OKAY        = 2'h0;
  localparam logic [1:0] RESP_SLVERR      = 2'h2;

endpackage

// *** core/dual_adc_link_if.sv ***
// Pin level link between the converter and its controller
`timescale 1ns/100ps
interface dual_adc_link_if;
  logic adc_clock;
  logic conversion_trigger;
  logic read_sync;
  logic output_select_n;
  logic channel_count_select;
  logic output_port_select;
  logic pair_select;
  logic busy;
  logic serial_a;
  logic serial_a_oe;
  logic serial_b;
  logic serial_b_oe;
  logic serial_a_pin;
  logic serial_b_pin;

  // Level seen by the controller; a released pin reads low
  assign serial_a_pin = serial_a_oe & serial_a;
  assign serial_b_pin = serial_b_oe & serial_b;

  modport device (
    input  adc_clock, conversion_trigger, read_sync, output_select_n,
    input  channel_count_select, output_port_select, pair_select,
    output busy, serial_a, serial_a_oe, serial_b, serial_b_oe
  );

  modport host (
    output adc_clock, conversion_trigger, read_sync, output_select_n,
    output channel_count_select, output_port_select, pair_select,
    input  busy, serial_a_pin, serial_b_pin
  );
endinterface

// *** core/pin_sync.sv ***
// Two flip-flop synchroniser for a group of pins
`timescale 1ns/100ps
module pin_sync
  import dual_adc_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             reset,
  // Pins and their synchronised copies
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } state_type;

  state_type state_q;
  state_type state_d;

  always_comb
  begin
    state_d        = state_q;
    state_d.first  = async_in;
    state_d.second = state_q.first;
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      state_q <= '0;
    else
      state_q <= state_d;
  end

  assign sync_out = state_q.second;

endmodule

// *** core/dual_adc_device.sv ***
// Converter end: sequencing, channel choice and serial readout
`timescale 1ns/100ps
module dual_adc_device
  import dual_adc_pkg::*;
(
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 reset,
  // Link to the controller
  dual_adc_link_if.device           link,
  // Analog stand-ins, two's complement codes
  input  wire logic [DATA_BITS-1:0] sample_a0,
  input  wire logic [DATA_BITS-1:0] sample_a1,
  input  wire logic [DATA_BITS-1:0] sample_b0,
  input  wire logic [DATA_BITS-1:0] sample_b1,
  // Converter state
  output logic                      sample_hold,
  output logic                      converting_pair
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic                 clock_prev;
    logic                 trigger_prev;
    logic                 active;
    logic                 long_frame;
    logic [5:0]           count;
    logic                 current_pair;
    logic                 next_pair;
    logic                 four_channel;
    logic [DATA_BITS-1:0] result_a;
    logic [DATA_BITS-1:0] result_b;
    logic                 busy;
    logic                 sample_hold;
    logic                 serial_a;
    logic                 serial_a_oe;
    logic                 serial_b;
    logic                 serial_b_oe;
  } state_type;

  state_type state_q;
  state_type state_d;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [SYNC_PINS_DEVICE-1:0] pins_sync;
  logic                        adc_clock_s;
  logic                        trigger_s;
  logic                        select_n_s;
  logic                        channel_count_s;
  logic                        output_port_s;
  logic                        pair_s;

  // Every link pin is foreign to this end, so two flops stand before
  // any use; all decisions below trail the pins by two cycles
  pin_sync #(
    .WIDTH (SYNC_PINS_DEVICE)
  ) pin_sync_inst (
    .clock    (clock),
    .reset    (reset),
    .async_in ({link.adc_clock, link.conversion_trigger,
                link.output_select_n, link.channel_count_select,
                link.output_port_select, link.pair_select}),
    .sync_out (pins_sync)
  );

  // Same order as packed above
  assign {adc_clock_s, trigger_s, select_n_s,
          channel_count_s, output_port_s, pair_s} = pins_sync;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic                  clock_rise;
  logic                  clock_fall;
  logic                  trigger_rise;
  logic [FRAME_BITS-1:0] word_a;
  logic [FRAME_BITS-1:0] word_b;
  logic [3:0]            bit_index;
  logic [5:0]            last_index;

  always_comb
  begin
    state_d      = state_q;
    // Edge detectors reset low, the idle level of both pins
    clock_rise   = adc_clock_s & ~state_q.clock_prev;
    clock_fall   = ~adc_clock_s & state_q.clock_prev;
    trigger_rise = trigger_s & ~state_q.trigger_prev;
    bit_index    = state_q.count[3:0];
    // Frame: pair flag, converter flag, data MSB first, two zeros
    word_a       = {state_q.current_pair, 1'b0, state_q.result_a, 2'b00};
    word_b       = {state_q.current_pair, 1'b1, state_q.result_b, 2'b00};
    // Single-port frames run on for the second word
    last_index   = state_q.long_frame ? 6'(2 * FRAME_BITS - 1)
                                      : 6'(FRAME_BITS - 1);

    // Previous levels for the edge detectors
    state_d.clock_prev   = adc_clock_s;
    state_d.trigger_prev = trigger_s;

    // Entering four-channel operation while idle restarts the sequence at pair 0, unless a trigger rises in the same cycle
    state_d.four_channel = channel_count_s;
    if (channel_count_s && !state_q.four_channel && !state_q.active)
    begin
      state_d.next_pair = 1'b0;
    end

    // A trigger that finds the block active is dropped; in single-port
    // mode the second frame is still going, so every second one is lost
    if (trigger_rise && !state_q.active)
    begin
      // Hold both channels at once, with no wait for the clock
      // Codes and pair for both converters are taken in this one cycle
      state_d.sample_hold  = 1'b1;
      state_d.active       = 1'b1;
      state_d.busy         = 1'b1;
      state_d.count        = '0;
      state_d.long_frame   = output_port_s;
      state_d.current_pair = state_q.next_pair;
      // Codes pass through unchanged as two's complement
      state_d.result_a = state_q.next_pair ? sample_a1 : sample_a0;
      state_d.result_b = state_q.next_pair ? sample_b1 : sample_b0;
      if (channel_count_s)
      begin
        state_d.next_pair = ~state_q.next_pair;
      end
    end
    else if (clock_rise && state_q.active)
    begin
      // One new bit per rising edge, sixteen per frame
      // Second frame carries converter B on the first output
      if (state_q.long_frame && state_q.count[4])
        state_d.serial_a = word_b[~bit_index];
      else
        state_d.serial_a = word_a[~bit_index];
      state_d.serial_b = word_b[~bit_index];
      state_d.count    = state_q.count + 6'd1;
      // Index 12 follows the third LSB, so busy may fall here
      if (state_q.count == 6'(BUSY_DROP_INDEX))
      begin
        state_d.busy        = 1'b0;
        state_d.sample_hold = 1'b0;
      end
      // Triggers during the second frame find the block active
      if (state_q.count == last_index)
      begin
        state_d.active = 1'b0;
      end
    end
    else if (clock_fall && state_q.active && !channel_count_s
             && state_q.count == 6'(FIRST_CYCLE_COUNT))
    begin
      // Latched once per conversion in two-channel mode, used by the conversion after this one
      state_d.next_pair = pair_s;
    end

    // Single-port mode leaves the second output floating
    state_d.serial_a_oe = ~select_n_s;
    state_d.serial_b_oe = ~select_n_s & ~state_d.long_frame;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Zero reset: pair 0 first, outputs released, not busy
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      state_q <= '0;
    else
      state_q <= state_d;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Every link output comes straight from a flop
  assign link.busy        = state_q.busy;
  assign link.serial_a    = state_q.serial_a;
  assign link.serial_a_oe = state_q.serial_a_oe;
  assign link.serial_b    = state_q.serial_b;
  assign link.serial_b_oe = state_q.serial_b_oe;
  assign sample_hold      = state_q.sample_hold;
  assign converting_pair  = state_q.current_pair;

endmodule

// *** core/dual_adc_host.sv ***
// Controller end: register slave, clock divider and frame capture
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/100ps
module dual_adc_host
  import dual_adc_pkg::*;
(
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 reset,
  // Link to the converter
  dual_adc_link_if.host             link,
  // Register slave, write side
  input  wire logic [ADDR_BITS-1:0] awaddr,
  input  wire logic                 awvalid,
  output logic                      awready,
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  input  wire logic                 wvalid,
  output logic                      wready,
  output logic [1:0]                bresp,
  output logic                      bvalid,
  input  wire logic                 bready,
  // Register slave, read side
  input  wire logic [ADDR_BITS-1:0] araddr,
  input  wire logic                 arvalid,
  output logic                      arready,
  output logic [31:0]               rdata,
  output logic [1:0]                rresp,
  output logic                      rvalid,
  input  wire logic                 rready,
  // Interrupt
  output logic                      irq
);

  typedef enum logic [1:0] {HOST_IDLE, HOST_ALIGN, HOST_TRIGGER, HOST_COLLECT} phase_type;

  typedef struct packed {
    phase_type                phase;
    logic [DIVIDER_BITS-1:0]  divider;
    logic                     adc_clock;
    logic                     trigger;
    logic [3:0]               trigger_count;
    logic [5:0]               rises;
    logic                     long_frame;
    logic [2*FRAME_BITS-1:0]  shift_a;
    logic [FRAME_BITS-1:0]    shift_b;
    logic [FRAME_BITS-1:0]    result_a;
    logic [FRAME_BITS-1:0]    result_b;
    logic [CONTROL_BITS-1:0]  control;
    logic [IRQ_BITS-1:0]      irq_status;
    logic [IRQ_BITS-1:0]      irq_enable;
    logic                     irq;
    logic                     aw_hold;
    logic                     w_hold;
    logic [ADDR_BITS-1:0]     waddr;
    logic [31:0]              wdata;
    logic                     wstrb_low;
    logic                     awready;
    logic                     wready;
    logic                     bvalid;
    logic [1:0]               bresp;
    logic                     arready;
    logic                     rvalid;
    logic [1:0]               rresp;
    logic [31:0]              rdata;
  } state_type;

  state_type state_q;
  state_type state_d;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic busy_s;
  logic serial_a_s;
  logic serial_b_s;

  pin_sync #(
    .WIDTH (SYNC_PINS_HOST)
  ) pin_sync_inst (
    .clock    (clock),
    .reset    (reset),
    .async_in ({link.busy, link.serial_a_pin, link.serial_b_pin}),
    .sync_out ({busy_s, serial_a_s, serial_b_s})
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic                start;
  logic                adc_rise;
  logic [IRQ_BITS-1:0] irq_set;
  logic [IRQ_BITS-1:0] irq_clear;
  logic [5:0]          frame_len;

  always_comb
  begin
    state_d   = state_q;
    start     = 1'b0;
    irq_set   = '0;
    irq_clear = '0;
    adc_rise  = (state_q.divider == DIVIDER_BITS'(1));
    frame_len = state_q.long_frame ? 6'(2 * FRAME_BITS) : 6'(FRAME_BITS);

    // Link clock from the divider, below the 8MHz best rate
    state_d.divider   = state_q.divider + DIVIDER_BITS'(1);
    // Level trails the count, so a reset starts a full high phase
    state_d.adc_clock = (state_q.divider < DIVIDER_BITS'(ADC_CLOCK_HALF));

    // Write channel
    if (awvalid && state_q.awready)
    begin
      state_d.aw_hold = 1'b1;
      state_d.waddr   = awaddr;
    end
    if (wvalid && state_q.wready)
    begin
      state_d.w_hold    = 1'b1;
      state_d.wdata     = wdata;
      state_d.wstrb_low = wstrb[0];
    end
    if (state_q.aw_hold && state_q.w_hold)
    begin
      state_d.aw_hold = 1'b0;
      state_d.w_hold  = 1'b0;
      state_d.bvalid  = 1'b1;
      state_d.bresp   = RESP_OKAY;
      unique case (state_q.waddr)
        CONTROL_OFFSET:
        begin
          if (state_q.wstrb_low)
          begin
            state_d.control = state_q.wdata[CONTROL_BITS-1:0];
            start           = state_q.wdata[CONTROL_START_BIT];
          end
        end
        IRQ_CLEAR_OFFSET:
        begin
          if (state_q.wstrb_low)
            irq_clear = state_q.wdata[IRQ_BITS-1:0];
        end
        IRQ_ENABLE_OFFSET:
        begin
          if (state_q.wstrb_low)
            state_d.irq_enable = state_q.wdata[IRQ_BITS-1:0];
        end
        default:
          state_d.bresp = RESP_SLVERR;
      endcase
    end
    if (state_q.bvalid && bready)
      state_d.bvalid = 1'b0;
    state_d.awready = ~state_d.aw_hold & ~state_d.bvalid;
    state_d.wready  = ~state_d.w_hold & ~state_d.bvalid;

    // Read channel
    if (arvalid && state_q.arready)
    begin
      state_d.rvalid = 1'b1;
      state_d.rresp  = RESP_OKAY;
      state_d.rdata  = '0;
      unique case (araddr)
        CONTROL_OFFSET:    state_d.rdata[CONTROL_BITS-1:0] = state_q.control;
        STATUS_OFFSET:
        begin
          state_d.rdata[STATUS_ACTIVE_BIT] = (state_q.phase != HOST_IDLE);
          state_d.rdata[STATUS_BUSY_BIT]   = busy_s;
        end
        IRQ_STATUS_OFFSET: state_d.rdata[IRQ_BITS-1:0] = state_q.irq_status;
        IRQ_CLEAR_OFFSET:  state_d.rdata = '0;
        IRQ_ENABLE_OFFSET: state_d.rdata[IRQ_BITS-1:0] = state_q.irq_enable;
        RESULT_A_OFFSET:   state_d.rdata[FRAME_BITS-1:0] = state_q.result_a;
        RESULT_B_OFFSET:   state_d.rdata[FRAME_BITS-1:0] = state_q.result_b;
        default:           state_d.rresp = RESP_SLVERR;
      endcase
    end
    if (state_q.rvalid && rready)
      state_d.rvalid = 1'b0;
    state_d.arready = ~state_d.rvalid;

    // Conversion sequencer
    unique case (state_q.phase)
      HOST_IDLE:
      begin
        if (start)
        begin
          state_d.phase      = HOST_ALIGN;
          state_d.long_frame = state_d.control[CONTROL_OUTPUT_PORT_BIT];
        end
      end
      HOST_ALIGN:
      begin
        // Raise just after a falling edge, far from any rising edge
        if (state_q.divider == DIVIDER_BITS'(ADC_CLOCK_HALF + 1))
        begin
          state_d.trigger       = 1'b1;
          state_d.trigger_count = '0;
          state_d.phase         = HOST_TRIGGER;
        end
      end
      HOST_TRIGGER:
      begin
        if (state_q.trigger_count == 4'(TRIGGER_HIGH_CYCLES - 1))
        begin
          state_d.trigger = 1'b0;
          state_d.rises   = '0;
          state_d.phase   = HOST_COLLECT;
        end
        else
          state_d.trigger_count = state_q.trigger_count + 4'd1;
      end
      HOST_COLLECT:
      begin
        // Bit n is read at rising edge n + 1
        if (adc_rise)
        begin
          if (state_q.rises != '0)
          begin
            state_d.shift_a = {state_q.shift_a[2*FRAME_BITS-2:0], serial_a_s};
            state_d.shift_b = {state_q.shift_b[FRAME_BITS-2:0], serial_b_s};
          end
          state_d.rises = state_q.rises + 6'd1;
          if (state_q.rises == frame_len)
          begin
            state_d.result_a = state_q.long_frame
                             ? state_d.shift_a[2*FRAME_BITS-1:FRAME_BITS]
                             : state_d.shift_a[FRAME_BITS-1:0];
            state_d.result_b = state_q.long_frame
                             ? state_d.shift_a[FRAME_BITS-1:0]
                             : state_d.shift_b;
            irq_set[IRQ_DONE_BIT] = 1'b1;
            state_d.phase         = HOST_IDLE;
          end
        end
      end
    endcase
    if (start && state_q.phase != HOST_IDLE)
      irq_set[IRQ_REFUSED_BIT] = 1'b1;

    // Sticky events; a new event beats its own clear
    state_d.irq_status = (state_q.irq_status & ~irq_clear) | irq_set;
    state_d.irq        = |(state_d.irq_status & state_d.irq_enable);
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      state_q <= '0;
    else
      state_q <= state_d;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign link.adc_clock            = state_q.adc_clock;
  assign link.conversion_trigger   = state_q.trigger;
  assign link.read_sync            = state_q.trigger;
  assign link.output_select_n      = 1'b0;
  assign link.channel_count_select = state_q.control[CONTROL_CHANNEL_COUNT_BIT];
  assign link.output_port_select   = state_q.control[CONTROL_OUTPUT_PORT_BIT];
  assign link.pair_select          = state_q.control[CONTROL_PAIR_BIT];
  assign awready = state_q.awready;
  assign wready  = state_q.wready;
  assign bvalid  = state_q.bvalid;
  assign bresp   = state_q.bresp;
  assign arready = state_q.arready;
  assign rvalid  = state_q.rvalid;
  assign rresp   = state_q.rresp;
  assign rdata   = state_q.rdata;
  assign irq     = state_q.irq;

endmodule

// *** verif/dual_adc_link_monitor.sv ***
// Checker for the link between converter and controller
`timescale 1ns/100ps
module dual_adc_link_monitor (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Link signals
  input wire logic adc_clock,
  input wire logic conversion_trigger,
  input wire logic read_sync,
  input wire logic output_select_n,
  input wire logic output_port_select,
  input wire logic busy,
  input wire logic serial_a,
  input wire logic serial_a_oe,
  input wire logic serial_b_oe
);
  // ----
  // Link properties
  // ----
  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  chk_clock_shape: assert property ($rose(adc_clock) |-> adc_clock [*4] ##1 !adc_clock [*4] ##1 adc_clock)
    else $error("converter clock shape wrong");
  chk_trigger_pulse: assert property ($rose(conversion_trigger) |=> !conversion_trigger)
    else $error("trigger pulse too long");
  chk_sync_copy: assert property (read_sync == conversion_trigger)
    else $error("read sync differs from trigger");
  chk_trigger_align: assert property ($rose(conversion_trigger) |-> !adc_clock [*3])
    else $error("trigger too close to clock rise");
  chk_busy_start: assert property ($rose(conversion_trigger) && !busy |-> ##[2:4] busy)
    else $error("busy late after trigger");
  chk_busy_holds: assert property ($rose(busy) |-> busy [*8])
    else $error("busy dropped early");
  chk_bit_stable: assert property ($rose(adc_clock) && serial_a_oe |-> $stable(serial_a) ##1 $stable(serial_a))
    else $error("serial bit moved at clock rise");
  chk_output_on: assert property (!output_select_n [*6] |-> serial_a_oe)
    else $error("serial output not driven");
  chk_b_off: assert property ($rose(busy) && output_port_select |-> ##[0:2] !serial_b_oe)
    else $error("second output driven in single port mode");
endmodule

// *** verif/dual_adc_conversion_serial_out_tb.sv ***
// Testbench for the converter and controller joined by the link
`timescale 1ns/100ps
module dual_adc_conversion_serial_out_tb;
  import dual_adc_pkg::*;
  logic                 clock = 0, reset = 1, p = 0, prev_pair = 0;
  logic [ADDR_BITS-1:0] awaddr = 0, araddr = 0;
  logic                 awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0]          wdata = 0, rdata, seed = 32'h2c57;
  logic [3:0]           wstrb = 4'hf;
  logic [1:0]           bresp, rresp;
  logic                 awready, wready, bvalid, arready, rvalid, irq, hold, cpair;
  logic [11:0]          smp [4] = '{default: 0};
  logic [11:0]          codes [4] = '{12'h7ff, 12'h000, 12'hfff, 12'h800};
  logic [33:0]          eq [$];
  int                   err_count = 0, num_checks = 0, n;

  dual_adc_link_if link ();
  dual_adc_device u_dual_adc_device (.clock(clock), .reset(reset), .link(link),
    .sample_a0(smp[0]), .sample_a1(smp[1]), .sample_b0(smp[2]), .sample_b1(smp[3]),
    .sample_hold(hold), .converting_pair(cpair));
  dual_adc_host u_dual_adc_host (.clock(clock), .reset(reset), .link(link),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .irq(irq));
  dual_adc_link_monitor u_dual_adc_link_monitor (.clock(clock), .reset(reset),
    .adc_clock(link.adc_clock), .conversion_trigger(link.conversion_trigger),
    .read_sync(link.read_sync), .output_select_n(link.output_select_n),
    .output_port_select(link.output_port_select), .busy(link.busy),
    .serial_a(link.serial_a), .serial_a_oe(link.serial_a_oe), .serial_b_oe(link.serial_b_oe));

  // ----
  // Clock, watchdog and helpers
  // ----
  initial forever #50 clock = ~clock;

  initial
  begin
    #2_000_000;
    err_count++;
    print_verdict();
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task print_verdict();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task check(input logic [33:0] seen, input logic [33:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  always @(posedge clock)
  begin
    if (rvalid && rready) check({rresp, rdata}, eq.pop_front());
    if (bvalid && bready) check({bresp, 32'h0}, eq.pop_front());
  end

  // ----
  // Bus cycles
  // ----
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ad, wd;
    eq.push_back({r, 32'h0});
    ad = 0;
    wd = 0;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(ad && wd))
    begin
      @(posedge clock);
      if (awready) ad = 1;
      if (wready) wd = 1;
      awvalid <= !ad;
      wvalid <= !wd;
    end
    do @(posedge clock); while (bvalid !== 1'b1);
    bready <= 0;
  endtask

  task rd(input logic [7:0] a, input logic [33:0] e);
    eq.push_back(e);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge clock); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge clock); while (rvalid !== 1'b1);
    rready <= 0;
  endtask

  task do_reset();
    reset <= 1;
    repeat (16) @(posedge clock);
    reset <= 0;
    prev_pair = 0;
    repeat (2) @(posedge clock);
    wr(IRQ_ENABLE_OFFSET, 32'h1, RESP_OKAY);
  endtask

  // One conversion with both frames read back
  task conv(input logic cc, op, sel, pr, dbl, input logic [11:0] c);
    logic [11:0] v [4];
    logic [31:0] ctl;
    ctl = {28'h0, 1'b1, sel, op, cc};
    for (int k = 0; k < 4; k++)
    begin
      seed = lfsr(seed);
      v[k] = seed[11:0];
    end
    v[pr] = c;
    for (int k = 0; k < 4; k++) smp[k] <= v[k];
    wr(CONTROL_OFFSET, ctl, RESP_OKAY);
    if (dbl)
    begin
      wr(CONTROL_OFFSET, ctl, RESP_OKAY);
      rd(IRQ_STATUS_OFFSET, {RESP_OKAY, 32'h2});
      check(irq, 1'b0);
    end
    n = 0;
    while (link.busy !== 1'b1) @(posedge clock);
    check(hold, 1'b1);
    check(cpair, pr);
    while (link.busy === 1'b1)
    begin
      @(posedge clock);
      n++;
    end
    check(n > 94 && n < 104, 1'b1);
    check(link.serial_b_oe, !op);
    rd(STATUS_OFFSET, {RESP_OKAY, 32'h1});
    while (irq !== 1'b1) @(posedge clock);
    rd(RESULT_A_OFFSET, {RESP_OKAY, 16'h0, pr, 1'b0, v[pr], 2'b00});
    rd(RESULT_B_OFFSET, {RESP_OKAY, 16'h0, pr, 1'b1, v[2 + pr], 2'b00});
    wr(IRQ_CLEAR_OFFSET, 32'h3, RESP_OKAY);
    check(irq, 1'b0);
    repeat (16) @(posedge clock);
  endtask

  // ----
  // Main sequence
  // ----
  initial
  begin
    do_reset();
    rd(CONTROL_OFFSET, {RESP_OKAY, 32'h0});
    rd(IRQ_ENABLE_OFFSET, {RESP_OKAY, 32'h1});
    rd(STATUS_OFFSET, {RESP_OKAY, 32'h0});
    rd(8'h1c, {RESP_SLVERR, 32'h0});
    wr(8'h1c, 32'h1, RESP_SLVERR);
    wr(STATUS_OFFSET, 32'h1, RESP_SLVERR);
    for (int i = 0; i < 6; i++)
    begin
      seed = lfsr(seed);
      p = seed[3];
      conv(1'b0, i[0], p, prev_pair, i == 2, codes[i % 4]);
      prev_pair = p;
    end
    conv(1'b1, 1'b0, seed[5], 1'b0, 1'b0, codes[1]);
    do_reset();
    for (int i = 0; i < 4; i++) conv(1'b1, i[1], seed[i], i[0], 1'b0, codes[i]);
    print_verdict();
  end
endmodule
